// File: include/fixture_io_consts.svh
// Constants for the digital output port and fixture interlock
`ifndef FIXTURE_IO_CONSTS_SVH
`define FIXTURE_IO_CONSTS_SVH
`define PORT_WIDTH        4
`define PORT_RESET_VALUE  4'h0
`define SYNC_STAGES       2
`endif

// File: include/fixture_io_pkg.sv
// Types shared by the output port and interlock logic
package fixture_io_pkg;
  typedef enum logic [1:0] {
    SRC_OFF,
    SRC_ON,
    SRC_TRIPPED
  } src_state_t;
endpackage

// File: core/pin_sync.sv
// Two-stage synchroniser for an asynchronous pin
`timescale 1ns/1ps
module pin_sync
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level
);
  logic meta_r;
  logic meta_nxt;
  logic level_r;
  logic level_nxt;

  always_comb
  begin
    meta_nxt  = i_pin;
    level_nxt = meta_r;
  end

  // Reset to high so an open fixture line reads as lid open
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_r  <= 1'b1;
      level_r <= 1'b1;
    end
    else
    begin
      meta_r  <= meta_nxt;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;
endmodule // pin_sync

// File: core/fixture_interlock_digital_out.sv
// Four-line digital output port with fixture output enable interlock
`timescale 1ns/1ps
`include "fixture_io_consts.svh"
module fixture_interlock_digital_out
#(
  parameter int WIDTH = `PORT_WIDTH
)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_local_write,
  input  wire logic [WIDTH-1:0] i_port_value_setting,
  input  wire logic             i_remote_write,
  input  wire logic [WIDTH-1:0] i_remote_port_value_command,
  input  wire logic             i_interlock_enable,
  input  wire logic             i_fixture_switch,
  input  wire logic             i_output_on_key,
  input  wire logic             i_output_off_req,
  output logic      [WIDTH-1:0] o_out_lines,
  output logic                  o_source_on,
  output logic                  o_interlock_tripped
);
  logic [WIDTH-1:0]         lines_r;
  logic [WIDTH-1:0]         lines_nxt;
  fixture_io_pkg::src_state_t state_r;
  fixture_io_pkg::src_state_t state_nxt;
  logic                     switch_s;
  logic                     on_r;
  logic                     on_nxt;
  logic                     trip_r;
  logic                     trip_nxt;

  pin_sync u_switch_sync
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_pin   (i_fixture_switch),
    .o_level (switch_s)
  );

  // Local entry wins a same-cycle collision; the front panel is the operator
  always_comb
  begin
    lines_nxt = lines_r;
    if (i_local_write)
      lines_nxt = i_port_value_setting;
    else if (i_remote_write)
      lines_nxt = i_remote_port_value_command;
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fixture_io_pkg::SRC_OFF:
      begin
        if (i_output_on_key && !(i_interlock_enable && switch_s))
          state_nxt = fixture_io_pkg::SRC_ON;
      end
      fixture_io_pkg::SRC_ON:
      begin
        if (i_interlock_enable && switch_s)
          state_nxt = fixture_io_pkg::SRC_TRIPPED;
        else if (i_output_off_req)
          state_nxt = fixture_io_pkg::SRC_OFF;
      end
      fixture_io_pkg::SRC_TRIPPED:
      begin
        // Lid closing alone never restores output; a key press must follow
        if (!i_interlock_enable || !switch_s)
        begin
          if (i_output_on_key)
            state_nxt = fixture_io_pkg::SRC_ON;
        end
      end
      default:
        state_nxt = fixture_io_pkg::SRC_OFF;
    endcase
    // Flags are decoded ahead of the register so both outputs leave a flop
    on_nxt   = (state_nxt == fixture_io_pkg::SRC_ON);
    trip_nxt = (state_nxt == fixture_io_pkg::SRC_TRIPPED);
  end

  // Lines keep their value across trips; the interlock gates only the source
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      lines_r <= `PORT_RESET_VALUE;
    else
      lines_r <= lines_nxt;
  end

  // Reset leaves the source off whatever the lid is doing
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_r <= fixture_io_pkg::SRC_OFF;
      on_r    <= 1'b0;
      trip_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      on_r    <= on_nxt;
      trip_r  <= trip_nxt;
    end
  end

  // Each line is an independent bit of the held value
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_line
      assign o_out_lines[g] = lines_r[g];
    end
  endgenerate

  assign o_source_on         = on_r;
  assign o_interlock_tripped = trip_r;

  // Source output on while the lid is seen open with the interlock active: the trip condition
  sequence trip_cause_s;
    o_source_on && i_interlock_enable && switch_s;
  endsequence

  // A key press that the interlock has no reason to block
  sequence key_allowed_s;
    i_output_on_key && (!i_interlock_enable || !switch_s);
  endsequence

  // Shut down by the interlock and waiting for a key press
  sequence tripped_s;
    o_interlock_tripped && !o_source_on;
  endsequence

  // Lid still seen open while the interlock is active
  sequence lid_open_s;
    i_interlock_enable && switch_s;
  endsequence

  // Checks watch the synchronised switch, so pin skew is not an error
  lines_follow_local_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    i_local_write |=> o_out_lines == $past(i_port_value_setting))
    else $error("lines did not take local value");

  lines_follow_remote_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (i_remote_write && !i_local_write)
      |=> o_out_lines == $past(i_remote_port_value_command))
    else $error("lines did not take remote value");

  lines_hold_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (!i_local_write && !i_remote_write) |=> $stable(o_out_lines))
    else $error("lines changed without a write");

  bypass_on_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (!o_source_on && !o_interlock_tripped && i_output_on_key
      && !i_interlock_enable) |=> o_source_on)
    else $error("output refused with interlock off");

  bypass_hold_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (o_source_on && !i_interlock_enable && !i_output_off_req)
      |=> o_source_on)
    else $error("switch acted with interlock off");

  refuse_on_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (!o_source_on && i_interlock_enable && switch_s) |=> !o_source_on)
    else $error("output turned on with switch high");

  force_off_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    trip_cause_s |=> !o_source_on && o_interlock_tripped)
    else $error("switch high did not force output off");

  no_self_restore_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    (o_interlock_tripped && !i_output_on_key) |=> !o_source_on)
    else $error("output restored without key press");

  no_restore_high_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    tripped_s ##0 lid_open_s |=> tripped_s)
    else $error("trip left while lid still open");

  restore_on_key_a: assert property (
    @(posedge i_clk)
    disable iff (i_reset)
    tripped_s ##0 key_allowed_s |=> o_source_on && !o_interlock_tripped)
    else $error("key press did not restore output");

  reset_off_a: assert property (
    @(posedge i_clk)
    $past(i_reset) |-> !o_source_on && o_out_lines == `PORT_RESET_VALUE)
    else $error("state not cleared by reset");

  reset_trip_a: assert property (
    @(posedge i_clk)
    $past(i_reset) |-> !o_interlock_tripped)
    else $error("trip flag not cleared by reset");
endmodule // fixture_interlock_digital_out

// File: tb/fixture_lid_model.sv
// Fixture lid switch driving the interlock pin
`timescale 1ns/1ps
module fixture_lid_model
(
  input  wire logic i_lid_open,
  output logic      o_switch
);
  // Closed lid grounds the pin, open lid lets the pull-up win
  assign o_switch = i_lid_open;
endmodule // fixture_lid_model

// File: tb/fixture_interlock_digital_out_bench.sv
// Self-checking bench for the output port and fixture interlock
`timescale 1ns/1ps
module fixture_interlock_digital_out_bench;
  logic       i_clk, i_reset, lw, rw, ien, key, off, lid, sw, son, trip;
  logic [3:0] lv, rv, lines;
  int         miscompares, check_count;
  fixture_lid_model lid_u (.i_lid_open(lid), .o_switch(sw));
  fixture_interlock_digital_out dut_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_local_write(lw), .i_port_value_setting(lv), .i_remote_write(rw),
    .i_remote_port_value_command(rv), .i_interlock_enable(ien),
    .i_fixture_switch(sw), .i_output_on_key(key), .i_output_off_req(off),
    .o_out_lines(lines), .o_source_on(son), .o_interlock_tripped(trip));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Strobe order is local, remote, key, off; the strobe stands for one
  // sampling edge and drops at that same edge, so calls leave an idle edge
  task automatic strobe(input logic [3:0] s, input logic [3:0] l, r);
    @(posedge i_clk);
    {lw, rw, key, off} <= s;
    lv <= l;
    rv <= r;
    @(posedge i_clk);
    {lw, rw, key, off} <= 4'h0;
    #1;
  endtask
  task automatic wait_trip();
    int n;
    n = 0;
    while (trip !== 1'b1 && n < 8)
    begin
      step(1);
      n++;
    end
    if (trip !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, trip, 1'b1);
      test_done();
    end
  endtask
  initial
  begin
    {lw, rw, key, off, ien, lid, i_reset} <= 7'h07;
    {lv, rv} <= 8'h00;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    step(1);
    chk({trip, 2'h0, son}, 4'h0);
    chk(lines, 4'h0);
    for (int v = 0; v < 16; v++)
    begin
      strobe(4'h8, v[3:0], 4'h0);
      chk(lines, v[3:0]);
      strobe(4'h4, 4'h0, ~v[3:0]);
      chk(lines, ~v[3:0]);
    end
    step(3);
    chk(lines, 4'h0);
    strobe(4'h8, 4'h9, 4'h0);
    step(3);
    chk(lines, 4'h9);
    strobe(4'hC, 4'h5, 4'hA);
    chk(lines, 4'h5);
    $display("test port lines done");
    @(posedge i_clk);
    ien <= 1'b1;
    strobe(4'h2, 4'h0, 4'h0);
    chk({3'h0, son}, 4'h0);
    @(posedge i_clk);
    lid <= 1'b0;
    step(3);
    strobe(4'h2, 4'h0, 4'h0);
    chk({3'h0, son}, 4'h1);
    strobe(4'h1, 4'h0, 4'h0);
    chk({3'h0, son}, 4'h0);
    strobe(4'h2, 4'h0, 4'h0);
    @(posedge i_clk);
    lid <= 1'b1;
    wait_trip();
    chk({3'h0, son}, 4'h0);
    strobe(4'h2, 4'h0, 4'h0);
    chk({trip, 2'h0, son}, 4'h8);
    strobe(4'h1, 4'h0, 4'h0);
    chk({trip, 2'h0, son}, 4'h8);
    @(posedge i_clk);
    lid <= 1'b0;
    step(5);
    chk({trip, 2'h0, son}, 4'h8);
    strobe(4'h2, 4'h0, 4'h0);
    chk({trip, 2'h0, son}, 4'h1);
    $display("test interlock done");
    @(posedge i_clk);
    ien <= 1'b0;
    lid <= 1'b1;
    step(5);
    chk({3'h0, son}, 4'h1);
    strobe(4'h1, 4'h0, 4'h0);
    strobe(4'h2, 4'h0, 4'h0);
    chk({trip, 2'h0, son}, 4'h1);
    @(posedge i_clk);
    ien <= 1'b1;
    wait_trip();
    @(posedge i_clk);
    ien <= 1'b0;
    step(2);
    chk({trip, 2'h0, son}, 4'h8);
    strobe(4'h2, 4'h0, 4'h0);
    chk({trip, 2'h0, son}, 4'h1);
    $display("test interlock off done");
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk({trip, 2'h0, son}, 4'h0);
    chk(lines, 4'h0);
    $display("test reset in run done");
    test_done();
  end
endmodule // fixture_interlock_digital_out_bench
